//--- scmc_top.sv
// serial channel mode and bus control registers with pin control
// assumes cpu access, shift datapath and timers share clk; pins are async
//
// Overview of operation
// - reset clears the serial mode register
// - clock field picks external, timer, prescaler
// - bus mode divides timer output by sixteen
// - mode field picks wire mode and bit order
// - push-pull in three-wire, open-drain otherwise
// - transmit-only three-wire frees serial input pin
// - unused data pin stays a port pin
// - wake-up bit chooses every-transfer or address interrupt
// - read-only flag shows address equals shift data
// - channel disabled forces comparison flag low
// - enable bit stops or runs the channel
// - reset clears the bus control register
// - device sets start flag on start condition
`timescale 1ns/1ps
`include "scmc_cfg.svh"

module scmc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic [7:0] slave_addr_reg,
  input wire logic [7:0] shift_reg_zero,
  input wire logic shift_out_load,
  input wire logic shift_out_bit,
  input wire logic xfer_done,
  input wire logic addr_rcvd,
  input wire logic irq_timing_select,
  input wire logic timer_two_output,
  input wire logic prescaler_clk,
  input wire logic tx_only,
  input wire logic port_out_a,
  input wire logic port_oe_a,
  input wire logic port_out_b,
  input wire logic port_oe_b,
  input wire logic bus_data_pin_a_in,
  output logic bus_data_pin_a_out,
  output logic bus_data_pin_a_oe,
  input wire logic bus_data_pin_b_in,
  output logic bus_data_pin_b_out,
  output logic bus_data_pin_b_oe,
  input wire logic ser_clk_pin_in,
  output logic ser_clk_pin_out,
  output logic ser_clk_pin_oe,
  output logic ser_clk,
  output logic msb_first,
  output logic serial_out_latch,
  output logic xfer_irq
);

  logic [7:0] serial_mode_reg;
  logic [7:0] bus_ctrl_reg;
  logic start_detect_flag;
  logic stop_pulse;
  logic start_pulse;
  logic [1:0] a_sync;
  logic [1:0] b_sync;
  logic [1:0] c_sync;
  logic sda_prev;
  logic scl_prev;
  logic next_clk;
  logic next_a_out;
  logic next_a_oe;
  logic next_b_out;
  logic next_b_oe;
  logic next_c_out;
  logic next_c_oe;
  logic wr_mode;
  logic wr_bus;
  logic channel_enable_bit;
  logic wakeup_select;
  logic bus_mode;
  logic sda_now;
  logic start_seen;
  logic stop_seen;
  logic next_enable;
  logic addr_equal;
  logic wake_hit;
  logic [2:0] mode_field;
  scmc_pkg::scmc_pinmode_t pinmode;

  assign wr_mode = cpu_wr && (cpu_addr == `SCMC_MODE_ADDR);
  assign wr_bus = cpu_wr && (cpu_addr == `SCMC_BUS_ADDR);
  assign channel_enable_bit = serial_mode_reg[`SCMC_EN_BIT];
  assign wakeup_select = serial_mode_reg[`SCMC_WAKE_BIT];
  assign mode_field = serial_mode_reg[`SCMC_MODE_HI:`SCMC_MODE_LO];
  assign addr_equal = (slave_addr_reg == shift_reg_zero);
  // flag follows the enable being written, so a stopping write never
  // reads back with a stale match
  assign next_enable = wr_mode ? cpu_wdata[`SCMC_EN_BIT] : channel_enable_bit;

  // mode field decode; 3'b1x0 other than 110 is prohibited, treated as 3-wire
  always_comb begin
    if (mode_field == 3'b110) begin
      pinmode = scmc_pkg::SCMC_PIN_2W_B;
    end else if (mode_field == 3'b111) begin
      pinmode = scmc_pkg::SCMC_PIN_2W_A;
    end else begin
      pinmode = scmc_pkg::SCMC_PIN_3WIRE;
    end
  end

  // both two-wire variants count as bus modes for start detection
  assign bus_mode = (pinmode != scmc_pkg::SCMC_PIN_3WIRE);

  // mode changes are taken as written; the stop-first discipline is software's
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_mode_reg <= `SCMC_MODE_RESET;
    end else begin
      if (wr_mode) begin
        serial_mode_reg[7] <= cpu_wdata[7];
        serial_mode_reg[5:0] <= cpu_wdata[5:0];
      end
      serial_mode_reg[`SCMC_MATCH_BIT] <= next_enable
        && addr_equal;
    end
  end

  // bus control: busy and ack enable are plain storage here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ctrl_reg <= `SCMC_BUS_RESET;
    end else if (wr_bus) begin
      bus_ctrl_reg <= {cpu_wdata[`SCMC_BUSY_BIT], 1'b0,
                       cpu_wdata[`SCMC_ACKEN_BIT], 5'b0_0000};
    end
  end

  // trigger bits live one cycle and read back as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_pulse <= 1'b0;
      start_pulse <= 1'b0;
    end else begin
      stop_pulse <= wr_bus && cpu_wdata[`SCMC_STOPTRIG_BIT]
                    && channel_enable_bit;
      start_pulse <= wr_bus && cpu_wdata[`SCMC_STARTTRIG_BIT]
                     && channel_enable_bit;
    end
  end

  // idle high; stop beats start, both beat the shift path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_out_latch <= 1'b1;
    end else if (stop_pulse) begin
      serial_out_latch <= 1'b1;
    end else if (start_pulse) begin
      serial_out_latch <= 1'b0;
    end else if (shift_out_load && channel_enable_bit) begin
      serial_out_latch <= shift_out_bit;
    end
  end

  // pin inputs are asynchronous; two stages before any use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_sync <= 2'b11;
      b_sync <= 2'b11;
      c_sync <= 2'b11;
    end else begin
      a_sync <= {a_sync[0], bus_data_pin_a_in};
      b_sync <= {b_sync[0], bus_data_pin_b_in};
      c_sync <= {c_sync[0], ser_clk_pin_in};
    end
  end

  assign sda_now = (pinmode == scmc_pkg::SCMC_PIN_2W_A) ? a_sync[1]
                                                         : b_sync[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_prev <= 1'b1;
      scl_prev <= 1'b1;
    end else begin
      sda_prev <= sda_now;
      scl_prev <= c_sync[1];
    end
  end

  // start: data falls while clock high; stop: data rises while clock high
  assign start_seen = bus_mode && channel_enable_bit && c_sync[1]
                      && scl_prev && sda_prev && !sda_now;
  assign stop_seen = bus_mode && c_sync[1] && scl_prev
                     && !sda_prev && sda_now;

  // a start in the same cycle as a stop or a clear wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_detect_flag <= 1'b0;
    end else if (start_seen) begin
      start_detect_flag <= 1'b1;
    end else if (stop_seen || !channel_enable_bit) begin
      start_detect_flag <= 1'b0;
    end
  end

  assign wake_hit = bus_mode && addr_rcvd && start_detect_flag
                    && irq_timing_select
                    && addr_equal;

  // wake-up relies on software having set the interrupt timing bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_irq <= 1'b0;
    end else if (!channel_enable_bit) begin
      xfer_irq <= 1'b0;
    end else if (!wakeup_select) begin
      xfer_irq <= xfer_done;
    end else begin
      xfer_irq <= wake_hit;
    end
  end

  // external clock arrives through the pin synchroniser: keep it below clk/4
  scmc_clk_sel u_clk_sel (
    .clk(clk),
    .rst_n(rst_n),
    .enable(channel_enable_bit),
    .bus_mode(bus_mode),
    .clk_src(serial_mode_reg[`SCMC_SRC_HI:`SCMC_SRC_LO]),
    .timer_two_output(timer_two_output),
    .prescaler_clk(prescaler_clk),
    .ext_clk_sync(c_sync[1]),
    .sel_clk(next_clk)
  );

  scmc_pin_mux u_pin_mux (
    .enable(channel_enable_bit),
    .pinmode(pinmode),
    .tx_only(tx_only),
    .int_clk(serial_mode_reg[`SCMC_SRC_HI]),
    .ser_clk(ser_clk),
    .out_latch(serial_out_latch),
    .port_out_a(port_out_a),
    .port_oe_a(port_oe_a),
    .port_out_b(port_out_b),
    .port_oe_b(port_oe_b),
    .pin_a_out(next_a_out),
    .pin_a_oe(next_a_oe),
    .pin_b_out(next_b_out),
    .pin_b_oe(next_b_oe),
    .pin_c_out(next_c_out),
    .pin_c_oe(next_c_oe)
  );

  // clock parked high while stopped, the idle level of the bus
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_clk <= 1'b1;
      msb_first <= 1'b1;
    end else begin
      ser_clk <= channel_enable_bit ? next_clk : 1'b1;
      msb_first <= bus_mode || !mode_field[0];
    end
  end

  // pins registered so a mode write never glitches a line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_data_pin_a_out <= 1'b0;
      bus_data_pin_a_oe <= 1'b0;
      bus_data_pin_b_out <= 1'b0;
      bus_data_pin_b_oe <= 1'b0;
      ser_clk_pin_out <= 1'b0;
      ser_clk_pin_oe <= 1'b0;
    end else begin
      bus_data_pin_a_out <= next_a_out;
      bus_data_pin_a_oe <= next_a_oe;
      bus_data_pin_b_out <= next_b_out;
      bus_data_pin_b_oe <= next_b_oe;
      ser_clk_pin_out <= next_c_out;
      ser_clk_pin_oe <= next_c_oe;
    end
  end

  // unmapped addresses read as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_rd && cpu_addr == `SCMC_MODE_ADDR) begin
      cpu_rdata <= serial_mode_reg;
    end else if (cpu_rd && cpu_addr == `SCMC_BUS_ADDR) begin
      cpu_rdata <= bus_ctrl_reg | {4'h0, start_detect_flag, 3'b000};
    end else begin
      cpu_rdata <= 8'h00;
    end
  end

endmodule // scmc_top

//--- scmc_cfg.svh
// offsets, field positions, reset values and counts of the serial mode block
// assumes an 8-bit cpu data path and a 16-bit cpu address
`ifndef SCMC_CFG_SVH
`define SCMC_CFG_SVH

`define SCMC_MODE_ADDR 16'hff60
`define SCMC_BUS_ADDR 16'hff61
`define SCMC_MODE_RESET 8'h00
`define SCMC_BUS_RESET 8'h00

// serial mode register fields
`define SCMC_EN_BIT 7
`define SCMC_MATCH_BIT 6
`define SCMC_WAKE_BIT 5
`define SCMC_MODE_HI 4
`define SCMC_MODE_LO 2
`define SCMC_SRC_HI 1
`define SCMC_SRC_LO 0

// bus control register fields
`define SCMC_BUSY_BIT 7
`define SCMC_ACKEN_BIT 5
`define SCMC_STARTDET_BIT 3
`define SCMC_STARTTRIG_BIT 1
`define SCMC_STOPTRIG_BIT 0

// last count of timer two rising edges in a half period of the bus clock (8 edges per half, divide by 16)
`define SCMC_TIMER_HALF 4'h7

`endif

//--- scmc_pkg.sv
// types shared by the serial mode control block
// constants live in scmc_cfg.svh
package scmc_pkg;

  typedef enum logic [1:0] {
    SCMC_PIN_3WIRE,
    SCMC_PIN_2W_B,
    SCMC_PIN_2W_A
  } scmc_pinmode_t;

  typedef enum logic [1:0] {
    SCMC_SRC_EXT,
    SCMC_SRC_TIMER,
    SCMC_SRC_PRESC
  } scmc_src_t;

endpackage

//--- scmc_clk_sel.sv
// shift clock source selection with divide by 16 of the timer output in bus mode
// assumes ext_clk_sync is already synchronised and timer/prescaler share clk
`timescale 1ns/1ps
`include "scmc_cfg.svh"

module scmc_clk_sel (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic bus_mode,
  input wire logic [1:0] clk_src,
  input wire logic timer_two_output,
  input wire logic prescaler_clk,
  input wire logic ext_clk_sync,
  output logic sel_clk
);

  logic timer_prev;
  logic [3:0] edge_cnt;
  logic div_clk;
  scmc_pkg::scmc_src_t src;

  always_comb begin
    if (!clk_src[1]) begin
      src = scmc_pkg::SCMC_SRC_EXT;
    end else if (!clk_src[0]) begin
      src = scmc_pkg::SCMC_SRC_TIMER;
    end else begin
      src = scmc_pkg::SCMC_SRC_PRESC;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_prev <= 1'b0;
    end else begin
      timer_prev <= timer_two_output;
    end
  end

  // divider held in reset while stopped so each start is phase aligned
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_cnt <= 4'h0;
      div_clk <= 1'b0;
    end else if (!enable) begin
      edge_cnt <= 4'h0;
      div_clk <= 1'b0;
    end else if (timer_two_output && !timer_prev) begin
      if (edge_cnt == `SCMC_TIMER_HALF) begin
        edge_cnt <= 4'h0;
        div_clk <= ~div_clk;
      end else begin
        edge_cnt <= edge_cnt + 4'h1;
      end
    end
  end

  always_comb begin
    case (src)
      scmc_pkg::SCMC_SRC_EXT: sel_clk = ext_clk_sync;
      scmc_pkg::SCMC_SRC_TIMER: sel_clk = bus_mode ? div_clk
                                                  : timer_two_output;
      scmc_pkg::SCMC_SRC_PRESC: sel_clk = prescaler_clk;
      default: sel_clk = 1'b1;
    endcase
  end

endmodule // scmc_clk_sel

//--- scmc_pin_mux.sv
// pin function mapping for data, clock and port pins
// purely combinational; the caller registers every result
`timescale 1ns/1ps

module scmc_pin_mux (
  input wire logic enable,
  input scmc_pkg::scmc_pinmode_t pinmode,
  input wire logic tx_only,
  input wire logic int_clk,
  input wire logic ser_clk,
  input wire logic out_latch,
  input wire logic port_out_a,
  input wire logic port_oe_a,
  input wire logic port_out_b,
  input wire logic port_oe_b,
  output logic pin_a_out,
  output logic pin_a_oe,
  output logic pin_b_out,
  output logic pin_b_oe,
  output logic pin_c_out,
  output logic pin_c_oe
);

  always_comb begin
    pin_a_out = port_out_a;
    pin_a_oe = port_oe_a;
    pin_b_out = port_out_b;
    pin_b_oe = port_oe_b;
    pin_c_out = 1'b0;
    pin_c_oe = 1'b0;
    if (enable) begin
      case (pinmode)
        scmc_pkg::SCMC_PIN_3WIRE: begin
          // serial input unless transmit only frees it as a port bit
          pin_a_out = port_out_a;
          pin_a_oe = tx_only ? port_oe_a : 1'b0;
          pin_b_out = out_latch;
          pin_b_oe = 1'b1;
          pin_c_out = ser_clk;
          pin_c_oe = int_clk;
        end
        scmc_pkg::SCMC_PIN_2W_B: begin
          pin_b_out = 1'b0;
          pin_b_oe = ~out_latch;
          pin_c_out = 1'b0;
          pin_c_oe = int_clk & ~ser_clk;
          pin_a_out = port_out_a;
          pin_a_oe = port_oe_a;
        end
        scmc_pkg::SCMC_PIN_2W_A: begin
          pin_a_out = 1'b0;
          pin_a_oe = ~out_latch;
          pin_c_out = 1'b0;
          pin_c_oe = int_clk & ~ser_clk;
          pin_b_out = port_out_b;
          pin_b_oe = port_oe_b;
        end
        default: begin
          pin_c_oe = 1'b0;
        end
      endcase
    end
  end

endmodule // scmc_pin_mux

//--- scmc_top_properties.sv
// concurrent checks on the serial mode block top ports
// assumes the mode register changes only through cpu writes
`timescale 1ns/1ps
`include "scmc_cfg.svh"

module scmc_top_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic shift_out_load,
  input wire logic xfer_done,
  input wire logic port_out_a,
  input wire logic port_oe_a,
  input wire logic bus_data_pin_a_out,
  input wire logic bus_data_pin_a_oe,
  input wire logic bus_data_pin_b_out,
  input wire logic bus_data_pin_b_oe,
  input wire logic ser_clk_pin_out,
  input wire logic ser_clk_pin_oe,
  input wire logic msb_first,
  input wire logic serial_out_latch,
  input wire logic xfer_irq
);
  logic [7:0] mode;

  // mirror of the writable mode bits; the flag bit is never stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= 8'h00;
    end else if (cpu_wr && cpu_addr == `SCMC_MODE_ADDR) begin
      mode <= cpu_wdata & 8'hbf;
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_MODE_RD: assert property (cpu_rd && cpu_addr == `SCMC_MODE_ADDR
    |=> {cpu_rdata[7], cpu_rdata[5:0]} == {mode[7], mode[5:0]})
    else $error("mode register readback differs");
  AST_MATCH_OFF: assert property (cpu_rd && cpu_addr == `SCMC_MODE_ADDR
    && !mode[7] |=> !cpu_rdata[6])
    else $error("match flag set while stopped");
  AST_MSB: assert property (mode == $past(mode) && (!mode[4] || mode[3])
    |-> msb_first == (mode[4] || !mode[2]))
    else $error("bit order wrong for mode");
  AST_PUSH_PULL: assert property (mode[7] && !mode[4]
    && mode == $past(mode) && $stable(serial_out_latch)
    |-> bus_data_pin_b_oe && bus_data_pin_b_out == serial_out_latch)
    else $error("serial output not driven in three-wire");
  AST_OPEN_DRAIN: assert property (mode[7] && mode[4:2] == 3'h6
    && mode == $past(mode) |-> !(bus_data_pin_b_oe && bus_data_pin_b_out)
    && !(ser_clk_pin_oe && ser_clk_pin_out))
    else $error("bus line driven high");
  AST_PORT_A: assert property (mode[4:2] == 3'h6 && mode == $past(mode)
    |-> bus_data_pin_a_oe == $past(port_oe_a)
    && bus_data_pin_a_out == $past(port_out_a))
    else $error("unused data pin not a port");
  sequence stop_wr_s;
    cpu_wr && cpu_addr == `SCMC_BUS_ADDR && cpu_wdata[0] && mode[7];
  endsequence
  AST_STOP: assert property (stop_wr_s ##1 !shift_out_load
    |=> serial_out_latch)
    else $error("stop trigger did not set latch");
  AST_IRQ_OFF: assert property (!$past(mode[7]) |-> !xfer_irq)
    else $error("interrupt while stopped");
  AST_IRQ_EACH: assert property (mode[7] && !mode[5] && xfer_done
    |=> xfer_irq)
    else $error("no interrupt after transfer");

  cover property (mode[5] && xfer_irq);
  cover property (stop_wr_s);
  cover property (mode[7] && !msb_first);
endmodule // scmc_top_properties

bind scmc_top scmc_top_properties u_props (.clk, .rst_n, .cpu_addr, .cpu_wr,
  .cpu_rd, .cpu_wdata, .cpu_rdata, .shift_out_load, .xfer_done, .port_out_a,
  .port_oe_a, .bus_data_pin_a_out, .bus_data_pin_a_oe, .bus_data_pin_b_out,
  .bus_data_pin_b_oe, .ser_clk_pin_out, .ser_clk_pin_oe, .msb_first,
  .serial_out_latch, .xfer_irq);

//--- scmc_peer.sv
// serial peer on the clock and two data lines, pull-ups on all three
// assumes the bench chooses when the peer pulls a line low
`timescale 1ns/1ps

module scmc_peer (
  input wire logic a_out,
  input wire logic a_oe,
  input wire logic b_out,
  input wire logic b_oe,
  input wire logic c_out,
  input wire logic c_oe,
  input wire logic free_a,
  input wire logic free_b,
  input wire logic free_c,
  output logic a_in,
  output logic b_in,
  output logic c_in
);
  // wired-and: released lines float to the pull-up level
  assign a_in = (a_oe ? a_out : 1'h1) & free_a;
  assign b_in = (b_oe ? b_out : 1'h1) & free_b;
  assign c_in = (c_oe ? c_out : 1'h1) & free_c;
endmodule // scmc_peer

//--- scmc_top_tb.sv
// register sequence tests of the serial mode block
// assumes a pin peer with pull-ups and a cpu bus of one-cycle strobes
`timescale 1ns/1ps
`include "scmc_cfg.svh"

module scmc_top_tb;
  logic clk = 1'h0, rst_n = 1'h0, cpu_wr = 1'h0, cpu_rd = 1'h0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0] cpu_wdata = 8'h00, cpu_rdata, slave_addr_reg = 8'h00;
  logic [7:0] shift_reg_zero = 8'h00;
  logic shift_out_load = 1'h0, shift_out_bit = 1'h0, xfer_done = 1'h0;
  logic addr_rcvd = 1'h0, irq_timing_select = 1'h0, tmr_run = 1'h0;
  logic timer_two_output = 1'h0, prescaler_clk = 1'h0, tx_only = 1'h0;
  logic port_out_a = 1'h1, port_oe_a = 1'h1, port_out_b = 1'h1;
  logic port_oe_b = 1'h1, free_a = 1'h1, free_b = 1'h1, free_c = 1'h1;
  logic bus_data_pin_a_in, bus_data_pin_a_out, bus_data_pin_a_oe;
  logic bus_data_pin_b_in, bus_data_pin_b_out, bus_data_pin_b_oe;
  logic ser_clk_pin_in, ser_clk_pin_out, ser_clk_pin_oe;
  logic ser_clk, msb_first, serial_out_latch, xfer_irq, last;
  logic [7:0] modes [4] = '{8'h80, 8'h84, 8'h98, 8'h9c};
  logic [3:0] msb_t = 4'hd, a_oe_t = 4'h6, b_oe_t = 4'hb;
  int n_mismatch = 0, compares = 0, n;

  scmc_top dut (.clk, .rst_n, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata,
    .cpu_rdata, .slave_addr_reg, .shift_reg_zero, .shift_out_load,
    .shift_out_bit, .xfer_done, .addr_rcvd, .irq_timing_select,
    .timer_two_output, .prescaler_clk, .tx_only, .port_out_a, .port_oe_a,
    .port_out_b, .port_oe_b, .bus_data_pin_a_in, .bus_data_pin_a_out,
    .bus_data_pin_a_oe, .bus_data_pin_b_in, .bus_data_pin_b_out,
    .bus_data_pin_b_oe, .ser_clk_pin_in, .ser_clk_pin_out, .ser_clk_pin_oe,
    .ser_clk, .msb_first, .serial_out_latch, .xfer_irq);

  scmc_peer peer (.a_out(bus_data_pin_a_out), .a_oe(bus_data_pin_a_oe),
    .b_out(bus_data_pin_b_out), .b_oe(bus_data_pin_b_oe),
    .c_out(ser_clk_pin_out), .c_oe(ser_clk_pin_oe), .free_a, .free_b,
    .free_c, .a_in(bus_data_pin_a_in), .b_in(bus_data_pin_b_in),
    .c_in(ser_clk_pin_in));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    #1;
    if (tmr_run) timer_two_output = ~timer_two_output;
  end

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'h1;
    step(1);
    cpu_wr = 1'h0;
    step(1);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    cpu_addr = a;
    cpu_rd = 1'h1;
    step(1);
    cpu_rd = 1'h0;
    chk(cpu_rdata, exp);
    step(1);
  endtask

  task automatic irq_try(input logic wake, input logic exp);
    if (wake) addr_rcvd = 1'h1;
    else xfer_done = 1'h1;
    step(1);
    addr_rcvd = 1'h0;
    xfer_done = 1'h0;
    chk({7'h00, xfer_irq}, {7'h00, exp});
    step(1);
  endtask

  // cycles until the selected serial clock next changes, bounded
  task automatic wait_toggle();
    last = ser_clk;
    for (n = 0; n < 100 && ser_clk === last; n++) step(1);
  endtask

  task automatic test_done();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    step(3);
    rst_n = 1'h1;
    step(1);
    rd(`SCMC_MODE_ADDR, 8'h00);
    rd(`SCMC_BUS_ADDR, 8'h00);
    rd(16'hff62, 8'h00);
    wr(`SCMC_MODE_ADDR, 8'h5f);
    rd(`SCMC_MODE_ADDR, 8'h1f);
    for (int i = 0; i < 4; i++) begin
      tx_only = (i == 1);
      wr(`SCMC_MODE_ADDR, modes[i] & 8'h7f);
      wr(`SCMC_MODE_ADDR, modes[i]);
      step(2);
      chk({7'h00, msb_first}, {7'h00, msb_t[i]});
      chk({7'h00, bus_data_pin_a_oe}, {7'h00, a_oe_t[i]});
      chk({7'h00, bus_data_pin_b_oe}, {7'h00, b_oe_t[i]});
      wr(`SCMC_MODE_ADDR, modes[i] & 8'h7f);
    end
    wr(`SCMC_MODE_ADDR, 8'h03);
    wr(`SCMC_MODE_ADDR, 8'h83);
    last = 1'h0;
    for (int i = 0; i < 4; i++) begin
      prescaler_clk = i[0];
      step(1);
      chk({7'h00, ser_clk}, {7'h00, i[0]});
      chk({6'h00, ser_clk_pin_oe, ser_clk_pin_out}, {7'h01, last});
      last = i[0];
    end
    wr(`SCMC_MODE_ADDR, 8'h03);
    wr(`SCMC_MODE_ADDR, 8'h1e);
    wr(`SCMC_MODE_ADDR, 8'h9e);
    tmr_run = 1'h1;
    wait_toggle();
    wait_toggle();
    chk(n[7:0], 8'h10);
    tmr_run = 1'h0;
    wr(`SCMC_MODE_ADDR, 8'h1e);
    wr(`SCMC_MODE_ADDR, 8'h00);
    wr(`SCMC_MODE_ADDR, 8'h80);
    free_c = 1'h0;
    step(4);
    chk({7'h00, ser_clk}, 8'h00);
    free_c = 1'h1;
    step(4);
    chk({7'h00, ser_clk}, 8'h01);
    shift_out_load = 1'h1;
    step(1);
    shift_out_load = 1'h0;
    step(1);
    chk({7'h00, serial_out_latch}, 8'h00);
    wr(`SCMC_BUS_ADDR, 8'h01);
    chk({7'h00, serial_out_latch}, 8'h01);
    rd(`SCMC_BUS_ADDR, 8'h00);
    wr(`SCMC_BUS_ADDR, 8'h02);
    chk({7'h00, serial_out_latch}, 8'h00);
    wr(`SCMC_BUS_ADDR, 8'h01);
    chk({7'h00, serial_out_latch}, 8'h01);
    irq_try(1'h0, 1'h1);
    wr(`SCMC_MODE_ADDR, 8'h00);
    irq_try(1'h0, 1'h0);
    wr(`SCMC_MODE_ADDR, 8'h3c);
    wr(`SCMC_MODE_ADDR, 8'hbc);
    free_a = 1'h0;
    step(5);
    rd(`SCMC_BUS_ADDR, 8'h08);
    irq_timing_select = 1'h1;
    slave_addr_reg = 8'h5a;
    shift_reg_zero = 8'h5a;
    step(2);
    rd(`SCMC_MODE_ADDR, 8'hfc);
    irq_try(1'h1, 1'h1);
    irq_try(1'h0, 1'h0);
    shift_reg_zero = 8'ha5;
    step(2);
    rd(`SCMC_MODE_ADDR, 8'hbc);
    irq_try(1'h1, 1'h0);
    shift_reg_zero = 8'h5a;
    wr(`SCMC_MODE_ADDR, 8'h3c);
    rd(`SCMC_MODE_ADDR, 8'h3c);
    rd(`SCMC_BUS_ADDR, 8'h00);
    test_done();
  end

  initial begin
    #20000;
    n_mismatch++;
    test_done();
  end
endmodule // scmc_top_tb
